// file: rtl/dma_pkg.sv
// Operation
// - demand mode: transfer while request stays valid
// - demand request is level, never stored
// - demand request sampled entering state 1 or 5
// - type 010/011: memory to io, inc/dec
// - type 100/101: io to memory, inc/dec
// - type 000/001: memory to memory, polarity ignored
// - io address constant for whole transfer
// - base register write also loads current register
// - memory to io strobe and latch sequence
// - io to memory strobe and latch sequence
// - memory copy: read, hold byte, write
// - memory copy starts only by software request
// - memory copy keeps bus until terminal count
// - command bit 5 enables, disables, requests
// - register write disables enabled channel
// - requests to disabled channel are discarded
// - channel 1 preempts channel 0, which resumes
// - external master low request, low grant
// - count zero: terminal count out, status flag
// - auto reload on io types restores current registers, stays enabled
// - single mode: stored edge, one byte
// - bit 2 selects request polarity
package dma_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 2;
  // mode control and command field positions
  localparam int MODE_RELOAD_BIT = 0;
  localparam int MODE_DEMAND_BIT = 1;
  localparam int MODE_POL_BIT = 2;
  localparam int MODE_TYPE_LSB = 3;
  localparam int MODE_TYPE_MSB = 5;
  localparam int CMD_ENABLE_BIT = 5;
  // transfer type codes, lsb set means decrement
  localparam logic [2:0] TYPE_M2M_INC = 3'h0;
  localparam logic [2:0] TYPE_M2M_DEC = 3'h1;
  localparam logic [2:0] TYPE_M2IO_INC = 3'h2;
  localparam logic [2:0] TYPE_M2IO_DEC = 3'h3;
  localparam logic [2:0] TYPE_IO2M_INC = 3'h4;
  localparam logic [2:0] TYPE_IO2M_DEC = 3'h5;
  // reset values and last byte count
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COUNT_LAST = 16'h0001;

  typedef enum logic [2:0] {
    SEL_BASE_PORT,
    SEL_BASE_MEM,
    SEL_BASE_COUNT,
    SEL_MODE,
    SEL_COMMAND
  } cfg_sel_t;

  typedef struct packed {
    logic wr;
    logic chan;
    cfg_sel_t sel;
    logic [15:0] data;
  } cfg_write_t;

  typedef struct packed {
    logic mem_read_strobe_n;
    logic mem_write_strobe_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
  } strobe_t;

  localparam strobe_t STROBES_OFF = 4'hF;

  typedef struct packed {
    logic [15:0] base_port_address;
    logic [15:0] base_memory_address;
    logic [15:0] base_byte_count;
    logic [15:0] cur_port_address;
    logic [15:0] cur_memory_address;
    logic [15:0] cur_byte_count;
    logic [7:0] channel_mode_control;
    logic en;
    logic stored;
    logic tc;
  } chan_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_S1,
    ST_S2,
    ST_S3,
    ST_S4,
    ST_S5,
    ST_EXT
  } dma_state_t;
endpackage

// file: rtl/dma_byte_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module dma_byte_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // handshakes and honest full/empty
  assign in_ready = (cnt_q != CNT_FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and storage next values
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // dma_byte_buffer
`default_nettype wire

// file: rtl/dma_transfer_control.sv
`timescale 1ns/100ps
`default_nettype none
module dma_transfer_control (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] xfer_request,
  output logic [1:0] xfer_acknowledge_n,
  output logic [1:0] terminal_count_out,
  input wire dma_pkg::cfg_write_t cfg_write,
  input wire logic status_rd,
  input wire logic status_chan,
  output logic [1:0] channel_status,
  output logic [1:0] channel_enabled,
  output logic dma_bus_req,
  input wire logic cpu_bus_grant,
  input wire logic ext_master_bus_req_n,
  output logic ext_master_bus_grant_n,
  output logic [15:0] addr_out,
  output logic port_addr_latch_strobe,
  output dma_pkg::strobe_t bus_strobes,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe
);
  import dma_pkg::*;

  // reset release through two flops
  logic rst_meta_q, rst_n_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  chan_t ch_q [2];
  chan_t ch_d [2];
  logic [1:0] prevv_q, prevv_d;
  dma_state_t state_q, state_d;
  logic act_q, act_d;
  logic req_q, req_d;
  logic ext_grant_n_q, ext_grant_n_d;
  logic [1:0] ack_n_q, ack_n_d, tc_out_q, tc_out_d;
  logic [15:0] addr_q, addr_d;
  logic latch_q, latch_d;
  strobe_t strb_q, strb_d;
  logic [7:0] dout_q, dout_d;
  logic doe_q, doe_d;
  logic [1:0] valid, pend, pend_s4;
  logic [1:0] is_m2m;
  logic byte_done, copy_push, copy_pop;
  logic buf_in_ready, buf_out_valid;
  logic [7:0] buf_out_data;
  logic [2:0] act_type;

  // held byte of a memory copy
  dma_byte_buffer #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_copy_buf (
    .clk(mclk),
    .rst_n(rst_n_q),
    .in_valid(copy_push),
    .in_ready(buf_in_ready),
    .in_data(data_in),
    .out_valid(buf_out_valid),
    .out_ready(copy_pop),
    .out_data(buf_out_data)
  );

  // request qualification per channel
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      is_m2m[c] = (ch_q[c].channel_mode_control[MODE_TYPE_MSB:MODE_TYPE_LSB+1] == TYPE_M2M_INC[2:1]);
      valid[c] = ch_q[c].channel_mode_control[MODE_POL_BIT] ? xfer_request[c] : ~xfer_request[c];
      if (!ch_q[c].en) begin
        pend[c] = 1'b0;
      end else if (is_m2m[c]) begin
        pend[c] = 1'b1;
      end else if (ch_q[c].channel_mode_control[MODE_DEMAND_BIT]) begin
        pend[c] = valid[c];
      end else begin
        pend[c] = ch_q[c].stored;
      end
      pend_s4[c] = pend[c];
    end
    // after terminal count the active channel goes on only with reload
    if (!(ch_q[act_q].channel_mode_control[MODE_RELOAD_BIT] && !is_m2m[act_q])) begin
      pend_s4[act_q] = 1'b0;
    end
  end

  assign act_type = ch_q[act_q].channel_mode_control[MODE_TYPE_MSB:MODE_TYPE_LSB];

  // sequencer next state and bus outputs
  always_comb begin
    state_d = state_q;
    act_d = act_q;
    req_d = req_q;
    ext_grant_n_d = ext_grant_n_q;
    ack_n_d = 2'b11;
    tc_out_d = 2'b00;
    addr_d = addr_q;
    latch_d = 1'b0;
    strb_d = STROBES_OFF;
    dout_d = dout_q;
    doe_d = 1'b0;
    byte_done = 1'b0;
    copy_push = 1'b0;
    copy_pop = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (pend != 2'b00) begin
          req_d = 1'b1;
          if (req_q && cpu_bus_grant) begin
            act_d = pend[1];
            state_d = ST_S1;
          end
        end else if (!ext_master_bus_req_n) begin
          req_d = 1'b1;
          if (req_q && cpu_bus_grant) begin
            state_d = ST_EXT;
          end
        end else begin
          req_d = 1'b0;
        end
      end
      ST_S1: begin
        state_d = ST_S2;
      end
      ST_S2: begin
        if (is_m2m[act_q]) begin
          copy_push = !buf_out_valid && buf_in_ready;
          if (buf_out_valid) begin
            copy_pop = 1'b1;
            dout_d = buf_out_data;
            state_d = ST_S3;
          end
        end else begin
          state_d = ST_S3;
        end
      end
      ST_S3: begin
        byte_done = 1'b1;
        if (ch_q[act_q].cur_byte_count == COUNT_LAST) begin
          state_d = ST_S4;
        end else if (pend != 2'b00) begin
          act_d = pend[1];
          state_d = ST_S1;
        end else begin
          state_d = ST_S5;
        end
      end
      ST_S4: begin
        if (pend_s4 != 2'b00) begin
          act_d = pend_s4[1];
          state_d = ST_S1;
        end else begin
          state_d = ST_S5;
        end
      end
      ST_S5: begin
        req_d = 1'b0;
        state_d = ST_IDLE;
      end
      ST_EXT: begin
        ext_grant_n_d = 1'b0;
        if (ext_master_bus_req_n) begin
          ext_grant_n_d = 1'b1;
          req_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // outputs shown during the state being entered
    unique case (state_d)
      ST_S1: begin
        ack_n_d[act_d] = is_m2m[act_d];
        addr_d = ch_q[act_d].cur_byte_count;
      end
      ST_S2: begin
        ack_n_d[act_d] = is_m2m[act_d];
        addr_d = ch_q[act_d].cur_port_address;
        latch_d = 1'b1;
        if (act_type[2:1] == TYPE_M2IO_INC[2:1]) begin
          strb_d.io_write_strobe_n = 1'b0;
        end else if (act_type[2:1] == TYPE_IO2M_INC[2:1]) begin
          strb_d.io_read_strobe_n = 1'b0;
        end else begin
          strb_d.mem_read_strobe_n = 1'b0;
        end
      end
      ST_S3: begin
        ack_n_d[act_d] = is_m2m[act_d];
        addr_d = ch_q[act_d].cur_memory_address;
        if (act_type[2:1] == TYPE_M2IO_INC[2:1]) begin
          strb_d.mem_read_strobe_n = 1'b0;
        end else if (act_type[2:1] == TYPE_IO2M_INC[2:1]) begin
          strb_d.mem_write_strobe_n = 1'b0;
        end else begin
          strb_d.mem_write_strobe_n = 1'b0;
          doe_d = 1'b1;
        end
      end
      ST_S4: begin
        ack_n_d[act_d] = is_m2m[act_d];
        tc_out_d[act_d] = 1'b1;
        addr_d = ch_q[act_d].base_byte_count;
      end
      default: begin
      end
    endcase
  end

  // channel registers next values
  always_comb begin
    prevv_d = valid;
    for (int c = 0; c < 2; c++) begin
      ch_d[c] = ch_q[c];
      if (status_rd && status_chan == 1'(c)) begin
        ch_d[c].tc = 1'b0;
      end
      if (!ch_q[c].en) begin
        ch_d[c].stored = 1'b0;
      end else if (state_q == ST_S1 && act_q == 1'(c)) begin
        ch_d[c].stored = 1'b0;
      end else if (valid[c] && !prevv_q[c] && !(state_q == ST_S2 && act_q == 1'(c))) begin
        ch_d[c].stored = !ch_q[c].channel_mode_control[MODE_DEMAND_BIT];
      end
      if (cfg_write.wr && cfg_write.chan == 1'(c)) begin
        ch_d[c].en = 1'b0;
        ch_d[c].stored = 1'b0;
        unique case (cfg_write.sel)
          SEL_BASE_PORT: begin
            ch_d[c].base_port_address = cfg_write.data;
            ch_d[c].cur_port_address = cfg_write.data;
            ch_d[c].tc = 1'b0;
          end
          SEL_BASE_MEM: begin
            ch_d[c].base_memory_address = cfg_write.data;
            ch_d[c].cur_memory_address = cfg_write.data;
            ch_d[c].tc = 1'b0;
          end
          SEL_BASE_COUNT: begin
            ch_d[c].base_byte_count = cfg_write.data;
            ch_d[c].cur_byte_count = cfg_write.data;
            ch_d[c].tc = 1'b0;
          end
          SEL_MODE: begin
            ch_d[c].channel_mode_control = cfg_write.data[7:0];
            ch_d[c].tc = 1'b0;
          end
          SEL_COMMAND: begin
            ch_d[c].en = cfg_write.data[CMD_ENABLE_BIT];
          end
          default: begin
          end
        endcase
      end
    end
    // one byte moved: step addresses, count down
    if (byte_done) begin
      if (ch_q[act_q].channel_mode_control[MODE_TYPE_LSB]) begin
        ch_d[act_q].cur_memory_address = ch_q[act_q].cur_memory_address - 16'h0001;
        if (is_m2m[act_q]) begin // io port address never steps
          ch_d[act_q].cur_port_address = ch_q[act_q].cur_port_address - 16'h0001;
        end
      end else begin
        ch_d[act_q].cur_memory_address = ch_q[act_q].cur_memory_address + 16'h0001;
        if (is_m2m[act_q]) begin
          ch_d[act_q].cur_port_address = ch_q[act_q].cur_port_address + 16'h0001;
        end
      end
      ch_d[act_q].cur_byte_count = ch_q[act_q].cur_byte_count - 16'h0001;
    end
    // terminal count: flag set wins over read clear
    if (state_q == ST_S4) begin
      ch_d[act_q].tc = 1'b1;
      if (ch_q[act_q].channel_mode_control[MODE_RELOAD_BIT] && !is_m2m[act_q]) begin
        ch_d[act_q].cur_port_address = ch_q[act_q].base_port_address;
        ch_d[act_q].cur_memory_address = ch_q[act_q].base_memory_address;
        ch_d[act_q].cur_byte_count = ch_q[act_q].base_byte_count;
      end else begin
        ch_d[act_q].en = 1'b0;
      end
    end
  end

  // register all state
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int c = 0; c < 2; c++) begin
        ch_q[c] <= '{ADDR_RESET, ADDR_RESET, ADDR_RESET, ADDR_RESET, ADDR_RESET, ADDR_RESET,
                     MODE_RESET, 1'b0, 1'b0, 1'b0};
      end
      prevv_q <= 2'b00;
      state_q <= ST_IDLE;
      act_q <= 1'b0;
      req_q <= 1'b0;
      ext_grant_n_q <= 1'b1;
      ack_n_q <= 2'b11;
      tc_out_q <= 2'b00;
      addr_q <= ADDR_RESET;
      latch_q <= 1'b0;
      strb_q <= STROBES_OFF;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
    end else begin
      ch_q <= ch_d;
      prevv_q <= prevv_d;
      state_q <= state_d;
      act_q <= act_d;
      req_q <= req_d;
      ext_grant_n_q <= ext_grant_n_d;
      ack_n_q <= ack_n_d;
      tc_out_q <= tc_out_d;
      addr_q <= addr_d;
      latch_q <= latch_d;
      strb_q <= strb_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
    end
  end

  // outputs straight from flops
  assign xfer_acknowledge_n = ack_n_q;
  assign terminal_count_out = tc_out_q;
  assign channel_status = {ch_q[1].tc, ch_q[0].tc};
  assign channel_enabled = {ch_q[1].en, ch_q[0].en};
  assign dma_bus_req = req_q;
  assign ext_master_bus_grant_n = ext_grant_n_q;
  assign addr_out = addr_q;
  assign port_addr_latch_strobe = latch_q;
  assign bus_strobes = strb_q;
  assign data_out = dout_q;
  assign data_oe = doe_q;
endmodule // dma_transfer_control
`default_nettype wire

// file: tb/dma_transfer_control_props.sv
`timescale 1ns/100ps
`default_nettype none
module dma_transfer_control_props
  import dma_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire dma_pkg::cfg_write_t cfg_write,
  input wire logic [1:0] xfer_acknowledge_n,
  input wire logic [1:0] terminal_count_out,
  input wire logic [1:0] channel_status,
  input wire logic [1:0] channel_enabled,
  input wire logic dma_bus_req,
  input wire logic cpu_bus_grant,
  input wire logic ext_master_bus_req_n,
  input wire logic ext_master_bus_grant_n,
  input wire logic port_addr_latch_strobe,
  input wire dma_pkg::strobe_t bus_strobes,
  input wire logic data_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // io write phase with latch, then memory read phase
  property p_mem_to_io;
    $fell(bus_strobes.io_write_strobe_n) |-> port_addr_latch_strobe && xfer_acknowledge_n != 2'h3
      ##1 !port_addr_latch_strobe && !bus_strobes.mem_read_strobe_n;
  endproperty
  a_mem_to_io: assert property (p_mem_to_io) else $error("memory to io sequence broken");
  property p_io_to_mem;
    $fell(bus_strobes.io_read_strobe_n) |-> port_addr_latch_strobe && xfer_acknowledge_n != 2'h3
      ##1 !port_addr_latch_strobe && !bus_strobes.mem_write_strobe_n;
  endproperty
  a_io_to_mem: assert property (p_io_to_mem) else $error("io to memory sequence broken");
  property p_copy_write;
    $rose(data_oe) |-> !bus_strobes.mem_write_strobe_n && $past(!bus_strobes.mem_read_strobe_n) && xfer_acknowledge_n == 2'h3;
  endproperty
  a_copy_write: assert property (p_copy_write) else $error("copy write without prior read");
  property p_strobes_owned;
    bus_strobes != STROBES_OFF |-> dma_bus_req && cpu_bus_grant;
  endproperty
  a_strobes_owned: assert property (p_strobes_owned) else $error("strobe without bus ownership");
  property p_one_ack;
    $onehot0(~xfer_acknowledge_n);
  endproperty
  a_one_ack: assert property (p_one_ack) else $error("both acknowledges low");
  property p_tc_status;
    terminal_count_out != 2'h0 |=> (channel_status & $past(terminal_count_out)) == $past(terminal_count_out);
  endproperty
  a_tc_status: assert property (p_tc_status) else $error("terminal count without status flag");
  property p_write_enable;
    cfg_write.wr |=> channel_enabled[$past(cfg_write.chan)] == ($past(cfg_write.sel) == SEL_COMMAND && $past(cfg_write.data[5]));
  endproperty
  a_write_enable: assert property (p_write_enable) else $error("enable wrong after write");
  property p_ext_exclusive;
    !ext_master_bus_grant_n |-> $past(!ext_master_bus_req_n) && bus_strobes == STROBES_OFF && xfer_acknowledge_n == 2'h3;
  endproperty
  a_ext_exclusive: assert property (p_ext_exclusive) else $error("external grant misplaced");
  property p_ext_release;
    ext_master_bus_req_n && !ext_master_bus_grant_n |=> ext_master_bus_grant_n && !dma_bus_req;
  endproperty
  a_ext_release: assert property (p_ext_release) else $error("external grant not released");
endmodule // dma_transfer_control_props
`default_nettype wire

// file: tb/dma_bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
module dma_bus_partner
  import dma_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic dma_bus_req,
  input wire logic [15:0] addr_out,
  input wire dma_pkg::strobe_t bus_strobes,
  output logic cpu_bus_grant,
  output logic [7:0] data_in
);
  logic [1:0] wait_q;
  logic [7:0] noise_q;
  // arbiter: grant after a short or long wait, dropped one cycle after request falls
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_bus_grant <= 1'b0;
      wait_q <= 2'h0;
      noise_q <= 8'h00;
    end else begin
      noise_q <= noise_q + 8'h3B;
      if (!dma_bus_req) begin
        cpu_bus_grant <= 1'b0;
        wait_q <= slow ? 2'h3 : 2'h0;
      end else if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else begin
        cpu_bus_grant <= 1'b1; // held until request drops
      end
    end
  end
  // memory answers only while read strobe is low, else a changing pattern
  assign data_in = bus_strobes.mem_read_strobe_n ? noise_q : (addr_out[7:0] ^ 8'h5A);
endmodule // dma_bus_partner
`default_nettype wire

// file: tb/test_dma_transfer_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_dma_transfer_control;
  import dma_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, status_rd = 1'b0, status_chan = 1'b0, slow = 1'b0, latch_prev = 1'b0;
  logic ext_master_bus_req_n, ext_master_bus_grant_n, dma_bus_req, cpu_bus_grant, port_addr_latch_strobe, data_oe;
  logic [1:0] xfer_request, xfer_acknowledge_n, terminal_count_out, channel_status, channel_enabled;
  logic [15:0] addr_out;
  logic [7:0] data_in, data_out;
  cfg_write_t cfg_write;
  strobe_t bus_strobes;
  logic [15:0] port_seen[$], mem_seen[$];
  logic [7:0] data_seen[$];
  logic [1:0] ack_seen[$];
  int err_total = 0, num_checks = 0, tc_seen = 0, cycles = 0;

  dma_transfer_control DUT (.mclk(mclk), .rstn(rstn), .xfer_request(xfer_request),
    .xfer_acknowledge_n(xfer_acknowledge_n), .terminal_count_out(terminal_count_out), .cfg_write(cfg_write),
    .status_rd(status_rd), .status_chan(status_chan), .channel_status(channel_status),
    .channel_enabled(channel_enabled), .dma_bus_req(dma_bus_req), .cpu_bus_grant(cpu_bus_grant),
    .ext_master_bus_req_n(ext_master_bus_req_n), .ext_master_bus_grant_n(ext_master_bus_grant_n),
    .addr_out(addr_out), .port_addr_latch_strobe(port_addr_latch_strobe), .bus_strobes(bus_strobes),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  dma_bus_partner u_partner (.mclk(mclk), .rstn(rstn), .slow(slow), .dma_bus_req(dma_bus_req),
    .addr_out(addr_out), .bus_strobes(bus_strobes), .cpu_bus_grant(cpu_bus_grant), .data_in(data_in));

  always #50 mclk = ~mclk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // byte monitor: port phase on latch rise, memory phase on latch fall
  always @(negedge mclk) begin
    latch_prev <= port_addr_latch_strobe;
    if (port_addr_latch_strobe && !latch_prev) begin
      port_seen.push_back(addr_out);
      ack_seen.push_back(xfer_acknowledge_n);
    end
    if (!port_addr_latch_strobe && latch_prev) begin
      mem_seen.push_back(addr_out);
      data_seen.push_back(data_out);
    end
    if (terminal_count_out != 2'h0) tc_seen++;
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  function automatic logic [15:0] exp_addr(input logic [15:0] base, input logic dec, input int k);
    return dec ? base - 16'(k) : base + 16'(k);
  endfunction

  task automatic cfg(input logic ch, input cfg_sel_t sel, input logic [15:0] data);
    @(negedge mclk);
    cfg_write = '{1'b1, ch, sel, data};
    @(negedge mclk);
    cfg_write.wr = 1'b0;
  endtask

  task automatic idle();
    int w;
    w = 0;
    repeat (4) @(negedge mclk);
    while (dma_bus_req && w < 300) begin
      @(negedge mclk);
      w++;
    end
  endtask

  task automatic prog(input logic ch, input logic [2:0] ty, input logic pol, dem, rel,
                      input logic [15:0] port, mem, cnt);
    xfer_request[ch] = ~pol;
    cfg(ch, SEL_MODE, {8'h00, 2'h0, ty, pol, dem, rel});
    cfg(ch, SEL_BASE_PORT, port);
    cfg(ch, SEL_BASE_MEM, mem);
    cfg(ch, SEL_BASE_COUNT, cnt);
    port_seen = {};
    mem_seen = {};
    data_seen = {};
    ack_seen = {};
    tc_seen = 0;
  endtask

  task automatic xfer(input logic ch, input logic [2:0] ty, input logic pol, dem, rel,
                      input logic [15:0] port, mem, cnt, input int n);
    int k, w;
    logic io;
    io = ty > 3'h1;
    prog(ch, ty, pol, dem, rel, port, mem, cnt);
    cfg(ch, SEL_COMMAND, 16'h0020);
    if (io && dem) xfer_request[ch] = pol;
    for (k = 0; k < n; k++) begin
      if (io && !dem) begin
        @(negedge mclk);
        xfer_request[ch] = pol;
        @(negedge mclk);
        xfer_request[ch] = ~pol;
      end
      w = 0;
      while (mem_seen.size() <= k && w < 300) begin
        @(negedge mclk);
        w++;
      end
    end
    xfer_request[ch] = ~pol;
    idle();
    check(16'(rel ? port_seen.size() >= n : port_seen.size() == n), 16'h1, "byte count");
    for (k = 0; k < n; k++) begin
      check(port_seen[k], io ? port : exp_addr(port, ty[0], k % cnt), "port address");
      check(mem_seen[k], exp_addr(mem, ty[0], k % cnt), "memory address");
      check(16'(ack_seen[k]), io ? (ch ? 16'h1 : 16'h2) : 16'h3, "acknowledge");
      if (!io) check(16'(data_seen[k]), 16'(8'(exp_addr(port, ty[0], k % cnt)) ^ 8'h5A), "copied data");
    end
    check(16'(channel_enabled[ch]), 16'(rel), "enable after run");
    if (!rel) begin
      check(16'(tc_seen), 16'h1, "terminal count pulses");
      check(16'(channel_status[ch]), 16'h1, "status flag");
    end
    @(negedge mclk);
    status_chan = ch;
    status_rd = 1'b1;
    @(negedge mclk);
    status_rd = 1'b0;
    check(16'(channel_status[ch]), 16'h0, "status cleared by read");
    cfg(ch, SEL_COMMAND, 16'h0000);
  endtask

  initial begin
    int i, w;
    logic [15:0] c;
    void'($urandom(47977));
    xfer_request = 2'h0;
    ext_master_bus_req_n = 1'b1;
    cfg_write = '0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
    // every io type code, random channel, polarity, mode and arbiter speed; port stands for a spare io address
    for (i = 0; i < 12; i++) begin
      c = 16'(1 + $urandom % 3);
      slow = 1'($urandom);
      xfer(1'($urandom), 3'(2 + i % 4), 1'($urandom), 1'($urandom), 1'b0, 16'($urandom), 16'($urandom), c, int'(c));
    end
    // memory copy both directions, request bits set but ignored
    xfer(1'b0, TYPE_M2M_INC, 1'b0, 1'b1, 1'b0, 16'h00FE, 16'h8000, 16'h0003, 3);
    xfer(1'b1, TYPE_M2M_DEC, 1'b1, 1'b0, 1'b0, 16'h0001, 16'h0002, 16'h0003, 3);
    // auto reload in demand and single modes
    xfer(1'b1, TYPE_IO2M_INC, 1'b1, 1'b1, 1'b1, 16'h0055, 16'hFFFF, 16'h0002, 5);
    xfer(1'b0, TYPE_M2IO_DEC, 1'b0, 1'b0, 1'b1, 16'h0066, 16'h0000, 16'h0002, 3);
    // write to enabled channel disables it, later edge is dropped
    prog(1'b0, TYPE_M2IO_INC, 1'b1, 1'b0, 1'b0, 16'h0040, 16'h1000, 16'h0002);
    cfg(1'b0, SEL_COMMAND, 16'h0020);
    cfg(1'b0, SEL_BASE_PORT, 16'h0041);
    check(16'(channel_enabled[0]), 16'h0, "write disables");
    xfer_request[0] = 1'b1;
    repeat (10) @(negedge mclk);
    xfer_request[0] = 1'b0;
    check(16'(dma_bus_req), 16'h0, "disabled request");
    cfg(1'b0, SEL_COMMAND, 16'h0020);
    repeat (10) @(negedge mclk);
    check(16'(port_seen.size()), 16'h0, "request not stored");
    cfg(1'b0, SEL_COMMAND, 16'h0000);
    // simultaneous edges: channel 1 served first
    prog(1'b0, TYPE_M2IO_INC, 1'b1, 1'b0, 1'b0, 16'h0010, 16'h2000, 16'h0001);
    prog(1'b1, TYPE_IO2M_INC, 1'b1, 1'b0, 1'b0, 16'h0020, 16'h3000, 16'h0001);
    cfg(1'b0, SEL_COMMAND, 16'h0020);
    cfg(1'b1, SEL_COMMAND, 16'h0020);
    @(negedge mclk);
    xfer_request = 2'h3;
    @(negedge mclk);
    xfer_request = 2'h0;
    repeat (30) @(negedge mclk);
    idle();
    check(16'(ack_seen[0]), 16'h1, "first acknowledge");
    check(16'(ack_seen[1]), 16'h2, "second acknowledge");
    // external master holds its request until three cycles after it sees the grant
    @(negedge mclk);
    ext_master_bus_req_n = 1'b0;
    w = 0;
    while (ext_master_bus_grant_n && w < 50) begin
      @(negedge mclk);
      w++;
    end
    check(16'(ext_master_bus_grant_n), 16'h0, "external grant");
    repeat (3) @(negedge mclk);
    ext_master_bus_req_n = 1'b1;
    repeat (2) @(negedge mclk);
    check(16'({ext_master_bus_grant_n, dma_bus_req}), 16'h2, "external release");
    summarize();
  end
endmodule // test_dma_transfer_control

bind dma_transfer_control dma_transfer_control_props u_props (.mclk(mclk), .rstn(rstn), .cfg_write(cfg_write),
  .xfer_acknowledge_n(xfer_acknowledge_n), .terminal_count_out(terminal_count_out),
  .channel_status(channel_status), .channel_enabled(channel_enabled), .dma_bus_req(dma_bus_req),
  .cpu_bus_grant(cpu_bus_grant), .ext_master_bus_req_n(ext_master_bus_req_n),
  .ext_master_bus_grant_n(ext_master_bus_grant_n), .port_addr_latch_strobe(port_addr_latch_strobe),
  .bus_strobes(bus_strobes), .data_oe(data_oe));
`default_nettype wire
